//--- rtl/cc_timer_pkg.sv
// Contract
// - counter advances once every four clocks
// - selected capture edge copies counter to capture, except between capture high and low reads
// - edge select bit picks rising or falling
// - capture irq only when enable set
// - compare checked once per counter step
// - match drives level to pin, sets flag
// - compare irq only when enable set
// - level zero drives low, one drives high
// - counter reads never disturb counting
// - counter visible through main and alternate pairs
// - main low read clears wrap; alternate never
// - high byte read freezes low byte buffer
// - frozen buffer holds through repeated high reads
// - low read returns buffer, restores transparency
// - counter preset at reset, read only
// - wrap sets flag, irq when enabled
// - flag clears after status read then low access
// - compare high write suspends match until low write
package cc_timer_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h12;
   localparam logic [7:0] ADDR_STATUS = 8'h13;
   localparam logic [7:0] ADDR_CAP_HIGH = 8'h14;
   localparam logic [7:0] ADDR_CAP_LOW = 8'h15;
   localparam logic [7:0] ADDR_MATCH_HIGH = 8'h16;
   localparam logic [7:0] ADDR_MATCH_LOW = 8'h17;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h18;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h19;
   localparam logic [7:0] ADDR_SHADOW_HIGH = 8'h1A;
   localparam logic [7:0] ADDR_SHADOW_LOW = 8'h1B;
   localparam int BIT_CAP_IE = 7;
   localparam int BIT_CMP_IE = 6;
   localparam int BIT_WRAP_IE = 5;
   localparam int BIT_EDGE = 1;
   localparam int BIT_LEVEL = 0;
   localparam logic [15:0] COUNT_RESET = 16'hFFFC;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam logic [7:0] CONTROL_WMASK = 8'hE3;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   typedef struct packed {
      logic cap_ie;
      logic cmp_ie;
      logic wrap_ie;
      logic edge_rise;
      logic level;
   } control_s;
   typedef struct packed {
      logic capture;
      logic compare;
      logic wrap;
   } flags_s;
endpackage

//--- rtl/capture_compare_timer.sv
`timescale 1ns/1ns
module capture_compare_timer
   import cc_timer_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [7:0] writedata,
   output logic [7:0] readdata,
   output logic waitrequest,
   input wire logic capture_input_pin,
   output logic compare_output_pin,
   output logic irq
);
   // =====================================
   // address decode and register images
   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   function automatic logic addr_is_either(input logic [7:0] addr, input logic [7:0] main, input logic [7:0] alt);
      return addr == main || addr == alt;
   endfunction

   function automatic logic [7:0] control_byte(input control_s c);
      return {c.cap_ie, c.cmp_ie, c.wrap_ie, 3'h0, c.edge_rise, c.level};
   endfunction

   function automatic logic [7:0] status_byte(input flags_s f);
      return {f.capture, f.compare, f.wrap, 5'h00};
   endfunction

   // =====================================
   // bus handshake: one wait cycle, answer on second edge
   logic ack_reg;
   logic access;
   logic rd;
   logic wr;
   logic read_start;
   assign access = (read | write) & ~ack_reg;
   assign waitrequest = access;
   // read data is sampled at the edge that takes the request
   assign read_start = read & ~ack_reg;
   assign rd = read & ack_reg;
   assign wr = write & ack_reg;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ack_reg <= 1'h0;
      else
         ack_reg <= access;
   end

   // =====================================
   // register strobes at the answering edge
   logic rd_status;
   logic rd_cap_high;
   logic rd_cap_low;
   logic rd_count_low;
   logic wr_control;
   logic wr_match_high;
   logic wr_match_low;
   logic acc_match_low;
   assign rd_status = rd && addr_is(address, ADDR_STATUS);
   assign rd_cap_high = rd && addr_is(address, ADDR_CAP_HIGH);
   assign rd_cap_low = rd && addr_is(address, ADDR_CAP_LOW);
   assign rd_count_low = rd && addr_is(address, ADDR_COUNT_LOW);
   assign wr_control = wr && addr_is(address, ADDR_CONTROL);
   assign wr_match_high = wr && addr_is(address, ADDR_MATCH_HIGH);
   assign wr_match_low = wr && addr_is(address, ADDR_MATCH_LOW);
   assign acc_match_low = (rd | wr) && addr_is(address, ADDR_MATCH_LOW);

   // =====================================
   // prescaler and counter
   logic [1:0] prescale_reg;
   logic [15:0] count_reg;
   logic tick;
   assign tick = (prescale_reg == PRESCALE_LAST);
   logic [1:0] prescale_next;
   logic [15:0] count_next;
   assign prescale_next = prescale_reg + 2'h1;
   assign count_next = count_reg + 16'h0001;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         prescale_reg <= 2'h0;
      else
         prescale_reg <= prescale_next;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         count_reg <= COUNT_RESET;
      else if (tick)
         count_reg <= count_next;
   end

   // =====================================
   // control register
   control_s control_reg;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         control_reg <= '0;
      else if (wr_control)
      begin
         control_reg.cap_ie <= writedata[BIT_CAP_IE];
         control_reg.cmp_ie <= writedata[BIT_CMP_IE];
         control_reg.wrap_ie <= writedata[BIT_WRAP_IE];
         control_reg.edge_rise <= writedata[BIT_EDGE];
         control_reg.level <= writedata[BIT_LEVEL];
      end
   end

   // =====================================
   // capture pin synchroniser and edge detect
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic pin_level_reg;
   logic pin_settled;
   logic pin_rise;
   logic pin_fall;
   logic cap_edge;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= capture_input_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // a change counts once the last two stages agree
   assign pin_settled = (sync2_reg == sync3_reg);
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pin_level_reg <= 1'h0;
      else if (pin_settled)
         pin_level_reg <= sync3_reg;
   end

   assign pin_rise = pin_settled && sync3_reg && !pin_level_reg;
   assign pin_fall = pin_settled && !sync3_reg && pin_level_reg;
   assign cap_edge = control_reg.edge_rise ? pin_rise : pin_fall;

   // =====================================
   // capture register, inhibited between high and low reads
   logic [15:0] capture_reg;
   logic cap_hold_reg;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cap_hold_reg <= 1'b0;
      else if (rd_cap_high)
         cap_hold_reg <= 1'h1;
      else if (rd_cap_low)
         cap_hold_reg <= 1'h0;
   end

   // capture edges are lost while the pair is being read
   logic capture_take;
   assign capture_take = cap_edge && !cap_hold_reg;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         capture_reg <= 16'h0000;
      else if (capture_take)
         capture_reg <= count_reg;
   end

   // =====================================
   // compare register and match
   logic [15:0] match_reg;
   logic match_hold_reg;
   logic match_hit;
   logic pin_reg;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         match_reg <= 16'h0000;
      else if (wr_match_high)
         match_reg[15:8] <= writedata;
      else if (wr_match_low)
         match_reg[7:0] <= writedata;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         match_hold_reg <= 1'h0;
      else if (wr_match_high)
         match_hold_reg <= 1'h1;
      else if (wr_match_low)
         match_hold_reg <= 1'h0;
   end

   logic match_equal;
   assign match_equal = (count_reg == match_reg);
   assign match_hit = tick && !match_hold_reg && match_equal;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pin_reg <= 1'h0;
      else if (match_hit)
         pin_reg <= control_reg.level;
   end

   assign compare_output_pin = pin_reg;

   // =====================================
   // counter low byte latch
   logic [7:0] low_buf_reg;
   logic low_frozen_reg;
   logic high_read;
   logic low_read;
   logic high_start;
   assign high_read = rd && addr_is_either(address, ADDR_COUNT_HIGH, ADDR_SHADOW_HIGH);
   assign low_read = rd && addr_is_either(address, ADDR_COUNT_LOW, ADDR_SHADOW_LOW);
   // freeze at the edge that samples the high byte so both halves match
   assign high_start = read_start && addr_is_either(address, ADDR_COUNT_HIGH, ADDR_SHADOW_HIGH);
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         low_frozen_reg <= 1'b0;
      else if (high_read)
         low_frozen_reg <= 1'b1;
      else if (low_read)
         low_frozen_reg <= 1'b0;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         low_buf_reg <= 8'h00;
      else if (high_start && !low_frozen_reg)
         low_buf_reg <= count_reg[7:0];
   end

   // =====================================
   // status flags: armed by status read, cleared by low access
   flags_s flags_reg;
   flags_s armed_reg;
   flags_s set_now;
   flags_s clr_now;
   logic wrap_now;
   logic count_at_max;
   assign count_at_max = (count_reg == COUNT_MAX);
   assign wrap_now = tick && count_at_max;
   assign set_now.capture = cap_edge;
   assign set_now.compare = match_hit;
   assign set_now.wrap = wrap_now;
   // a set in the same cycle as a clear wins
   assign clr_now.capture = rd_cap_low && armed_reg.capture;
   assign clr_now.compare = acc_match_low && armed_reg.compare;
   assign clr_now.wrap = rd_count_low && armed_reg.wrap;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         flags_reg <= '0;
      else
         flags_reg <= set_now | (flags_reg & ~clr_now);
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         armed_reg <= '0;
      else if (rd_status)
         armed_reg <= flags_reg;
      else
         armed_reg <= armed_reg & ~clr_now;
   end

   // =====================================
   // interrupt request
   logic cap_request;
   logic cmp_request;
   logic wrap_request;
   logic any_request;
   assign cap_request = flags_reg.capture & control_reg.cap_ie;
   assign cmp_request = flags_reg.compare & control_reg.cmp_ie;
   assign wrap_request = flags_reg.wrap & control_reg.wrap_ie;
   assign any_request = cap_request | cmp_request | wrap_request;

   // level request, one cycle behind the flags
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'h0;
      else
         irq <= any_request;
   end

   // =====================================
   // read data
   logic [7:0] rdata_next;
   always_comb
   begin
      case (address)
         ADDR_CONTROL:
            rdata_next = control_byte(control_reg);
         ADDR_STATUS:
            rdata_next = status_byte(flags_reg);
         ADDR_CAP_HIGH:
            rdata_next = capture_reg[15:8];
         ADDR_CAP_LOW:
            rdata_next = capture_reg[7:0];
         ADDR_MATCH_HIGH:
            rdata_next = match_reg[15:8];
         ADDR_MATCH_LOW:
            rdata_next = match_reg[7:0];
         ADDR_COUNT_HIGH, ADDR_SHADOW_HIGH:
            rdata_next = count_reg[15:8];
         ADDR_COUNT_LOW, ADDR_SHADOW_LOW:
            rdata_next = low_frozen_reg ? low_buf_reg : count_reg[7:0];
         default:
            rdata_next = UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         readdata <= 8'h00;
      else if (read_start)
         readdata <= rdata_next;
   end
endmodule

//--- testbench/capture_compare_timer_chk.sv
`timescale 1ns/1ns
module capture_compare_timer_chk
   import cc_timer_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [7:0] writedata,
   input wire logic [7:0] readdata,
   input wire logic waitrequest,
   input wire logic compare_output_pin,
   input wire logic irq
);
   logic [7:0] ctl_reg, hi_reg, lo_reg;
   wire logic ack = !waitrequest && write;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_reg <= 8'h00;
         hi_reg <= 8'h00;
         lo_reg <= 8'h00;
      end
      else if (ack)
      begin
         if (address == ADDR_CONTROL) ctl_reg <= writedata & CONTROL_WMASK;
         if (address == ADDR_MATCH_HIGH) hi_reg <= writedata;
         if (address == ADDR_MATCH_LOW) lo_reg <= writedata;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence answer_s; waitrequest ##1 !waitrequest; endsequence
   sequence rd_s(a); read && !waitrequest && address == a; endsequence
   wait_answer_a: assert property ($rose(read || write) |-> answer_s) else $error("bad answer");
   status_zero_a: assert property (rd_s(ADDR_STATUS) |-> readdata[4:0] == 5'h00) else $error("status pad");
   control_back_a: assert property (rd_s(ADDR_CONTROL) |-> readdata == ctl_reg) else $error("control");
   match_high_a: assert property (rd_s(ADDR_MATCH_HIGH) |-> readdata == hi_reg) else $error("match hi");
   match_low_a: assert property (rd_s(ADDR_MATCH_LOW) |-> readdata == lo_reg) else $error("match lo");
   unmapped_zero_a: assert property (read && !waitrequest && address > ADDR_SHADOW_LOW
      |-> readdata == UNMAPPED_DATA) else $error("unmapped");
   irq_enable_a: assert property (irq |-> $past(ctl_reg[7:5]) != 3'h0) else $error("irq masked");
   pin_level_a: assert property ($changed(compare_output_pin)
      |-> compare_output_pin == $past(ctl_reg[BIT_LEVEL])) else $error("pin level");
endmodule
bind capture_compare_timer capture_compare_timer_chk capture_compare_timer_chk_inst (.clock, .rstn, .address,
   .read, .write, .writedata, .readdata, .waitrequest, .compare_output_pin, .irq);

//--- testbench/pin_partner.sv
`timescale 1ns/1ns
module pin_partner (
   input wire logic clock,
   input wire logic level,
   input wire logic [5:0] lag,
   output logic capture_input_pin
);
   initial capture_input_pin = 1'b0;
   // asynchronous pin, moves anywhere within the cycle
   always @(posedge clock) capture_input_pin <= #(lag) level;
endmodule

//--- testbench/test_capture_compare_timer.sv
`timescale 1ns/1ns
module test_capture_compare_timer;
   import cc_timer_pkg::*;
   logic clock = 0, rstn = 0, read = 0, write = 0, level = 0;
   logic [7:0] address = 8'h00, writedata = 8'h00, readdata, q, h, a;
   logic [5:0] lag = 6'h00;
   logic waitrequest, capture_input_pin, compare_output_pin, irq;
   logic [15:0] t;
   logic [7:0] ra [4] = '{ADDR_CONTROL, ADDR_MATCH_HIGH, ADDR_MATCH_LOW, 8'h5C};
   logic [7:0] rm [4] = '{8'hE3, 8'hFF, 8'hFF, 8'h00};
   int errors = 0, tests_run = 0, cyc = 0, t_ack, c, i, n;
   int seed = 32'hf0d1b8f8;
   always #20 clock = ~clock;
   always @(posedge clock) cyc <= rstn ? cyc + 1 : 0;
   capture_compare_timer capture_compare_timer_inst (.clock, .rstn, .address, .read, .write, .writedata,
      .readdata, .waitrequest, .capture_input_pin, .compare_output_pin, .irq);
   pin_partner pin_partner_inst (.clock, .level, .lag, .capture_input_pin);
   function automatic logic [15:0] cnt(input int k);
      return COUNT_RESET + 16'(k / 4);
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input bit near = 0);
      logic [15:0] d;
      d = g - e;
      tests_run++;
      if (g !== e && !(near && (d === 16'h0001 || d === 16'hFFFF)))
      begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic bus(input bit w, input logic [7:0] ad, input logic [7:0] d = 8'h00);
      n = 0;
      address <= ad;
      writedata <= d;
      read <= !w;
      write <= w;
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      if (n == 20)
      begin
         errors++;
         $display("[ERR] %0t no answer", $time);
      end
      q = readdata;
      t_ack = cyc;
      read <= 0;
      write <= 0;
      @(posedge clock);
   endtask
   task results;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #300000;
      errors++;
      results();
   end
   initial
   begin
      repeat (4) @(posedge clock);
      rstn <= 1;
      @(posedge clock);
      bus(1, ADDR_CONTROL, 8'h20);
      repeat (30) @(posedge clock);
      chk(irq, 1);
      bus(0, ADDR_STATUS);
      chk(q, 8'h60);
      bus(0, ADDR_SHADOW_LOW);
      bus(0, ADDR_STATUS);
      chk(q, 8'h60);
      bus(0, ADDR_COUNT_LOW);
      bus(0, ADDR_STATUS);
      chk(q, 8'h40);
      chk(irq, 0);
      for (i = 0; i < 4; i++)
      begin
         a = ADDR_COUNT_HIGH + 8'(2 * (i % 2));
         repeat ({$random(seed)} % 200) @(posedge clock);
         bus(1, a, 8'($random(seed)));
         bus(0, a + 8'h01);
         chk({8'h00, 8'(q - cnt(t_ack) + 8'h01)}, 16'h0001, 1);
         bus(0, a);
         h = q;
         c = t_ack;
         repeat (8 + {$random(seed)} % 32) @(posedge clock);
         bus(0, a);
         bus(0, a + 8'h01);
         chk({h, q}, cnt(c), 1);
      end
      for (i = 0; i < 2; i++)
      begin
         bus(1, ADDR_CONTROL, 8'h40 | 8'(i == 0));
         if (i == 1)
         begin
            t = cnt(cyc) + 16'h0010;
            bus(1, ADDR_MATCH_LOW, t[7:0]);
            bus(1, ADDR_MATCH_HIGH, t[15:8]);
            repeat (90) @(posedge clock);
            chk(compare_output_pin, 1);
         end
         t = cnt(cyc) + 16'h0008;
         bus(1, ADDR_MATCH_HIGH, t[15:8]);
         bus(1, ADDR_MATCH_LOW, t[7:0]);
         repeat (60) @(posedge clock);
         chk(compare_output_pin, i == 0);
         chk(irq, 1);
         bus(0, ADDR_STATUS);
         chk(q, 8'h40);
         bus(1, ADDR_MATCH_LOW, t[7:0]);
         bus(0, ADDR_STATUS);
         chk(q, 8'h00);
      end
      for (i = 0; i < 2; i++)
      begin
         level <= i;
         lag <= 6'({$random(seed)} % 40);
         repeat (8) @(posedge clock);
         bus(1, ADDR_CONTROL, i ? 8'h82 : 8'h00);
         level <= !i;
         repeat (8) @(posedge clock);
         bus(0, ADDR_STATUS);
         chk(q[7], 0);
         level <= i;
         c = cyc;
         repeat (8) @(posedge clock);
         chk(irq, i);
         bus(0, ADDR_STATUS);
         chk(q[7], 1);
         bus(0, ADDR_CAP_HIGH);
         h = q;
         bus(0, ADDR_CAP_LOW);
         chk({h, q}, cnt(c + 5), 1);
         bus(0, ADDR_STATUS);
         chk(q[7], 0);
      end
      ra[3] = 8'h40 | 8'($random(seed) & 8'h3F);
      for (i = 0; i < 4; i++)
      begin
         h = 8'($random(seed));
         bus(1, ra[i], h);
         bus(0, ra[i]);
         chk(q, h & rm[i]);
      end
      results();
   end
endmodule
